// ===== mem_decoder.sv
// Memory space decoder: internal ROM, data area, register window, external
`timescale 1ns/1ps
`default_nettype none
module mem_decoder
  import mem_decode_pkg::*;
#(
  parameter variant_t VARIANT = VAR_128K
)(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // Access request from the core
  input  wire logic     req_i,
  input  wire addr_t    addr_i,
  input  wire logic     reset_fetch_i,
  // Relocation command
  input  wire logic     reloc_valid_i,
  input  wire reloc_t   reloc_code_i,
  // Mode
  input  wire logic     ext_mode_i,
  // Decode result, registered
  output logic          valid_o,
  output target_e       target_o,
  output addr_t         offset_o,
  output logic          rom_sel_o,
  output logic          ram_sel_o,
  output logic          sfr_sel_o,
  output logic          gpr_sel_o,
  output logic          dreg_sel_o,
  output logic          ext_sel_o,
  output logic          vec_sel_o,
  output logic          tcall_sel_o,
  output logic          fcall_sel_o,
  output logic          reloc_high_o,
  output logic          reloc_done_o
);
  reloc_if rel ();

  reloc_latch u_latch (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .reloc_valid_i (reloc_valid_i),
    .reloc_code_i  (reloc_code_i),
    .rel           (rel)
  );

  function automatic addr_t data_lo(input variant_t v);
    case (v)
      VAR_48K:  data_lo = DATA_LO_48K;
      VAR_64K:  data_lo = DATA_LO_64K;
      VAR_96K:  data_lo = DATA_LO_96K;
      default:  data_lo = DATA_LO_128K;
    endcase
  endfunction

  function automatic addr_t rom_end(input variant_t v);
    case (v)
      VAR_48K:  rom_end = ROM_END_48K;
      VAR_64K:  rom_end = ROM_END_64K;
      VAR_96K:  rom_end = ROM_END_96K;
      default:  rom_end = ROM_END_128K;
    endcase
  endfunction

  function automatic logic in_rng(input addr_t a, input addr_t lo, input addr_t hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  localparam addr_t DLO = data_lo(VARIANT);
  localparam addr_t REND = rom_end(VARIANT);

  logic    in_data, in_rom, low_off;
  addr_t   low_addr;
  target_e tgt;

  always_comb begin
    // Low-64K image of the data area, used for sub-area decode
    low_addr = addr_i & PAGE_MASK;
    if (rel.high)
      in_data = in_rng(addr_i, DLO | HIGH_OFS, 20'hfffff);
    else
      in_data = in_rng(addr_i, DLO, PAGE_MASK);
    // Shadowed ROM hidden under low data area
    low_off = !rel.high && in_rng(addr_i, DLO, PAGE_MASK);
    // Full ROM only with high placement, except in VAR_48K, whose ROM ends below the data area
    in_rom = (addr_i <= REND) && !low_off;
    tgt = TGT_NONE;
    if (reset_fetch_i)
      tgt = (addr_i <= REND) ? TGT_ROM : (ext_mode_i ? TGT_EXT : TGT_NONE);
    else if (in_data)
      tgt = (low_addr >= SFR_BASE) ? TGT_SFR : TGT_RAM;
    else if (in_rom)
      tgt = TGT_ROM;
    else if (ext_mode_i)
      tgt = TGT_EXT;
  end

  logic    valid_reg, valid_next;
  target_e tgt_reg, tgt_next;
  addr_t   off_reg, off_next;
  logic    gpr_reg, gpr_next;
  logic    dreg_reg, dreg_next;
  logic    vec_reg, vec_next;
  logic    tcall_reg, tcall_next;
  logic    fcall_reg, fcall_next;
  logic    rom_reg, rom_next;
  logic    ram_reg, ram_next;
  logic    sfr_reg, sfr_next;
  logic    ext_reg, ext_next;
  logic    high_q_reg, high_q_next;
  logic    done_q_reg, done_q_next;

  always_comb begin
    valid_next = req_i;
    tgt_next   = req_i ? tgt : TGT_NONE;
    case (tgt)
      TGT_RAM: off_next = addr_i - (rel.high ? (DLO | HIGH_OFS) : DLO);
      TGT_SFR: off_next = low_addr - SFR_BASE;
      default: off_next = addr_i;
    endcase
    gpr_next   = req_i && tgt == TGT_RAM && in_rng(low_addr, GPR_BASE, GPR_END);
    dreg_next  = req_i && tgt == TGT_RAM && in_rng(low_addr, DREG_BASE, GPR_END);
    vec_next   = req_i && tgt == TGT_ROM && addr_i <= VEC_END;
    tcall_next = req_i && tgt == TGT_ROM && in_rng(addr_i, TCALL_BASE, TCALL_END);
    fcall_next = req_i && tgt == TGT_ROM && in_rng(addr_i, FCALL_BASE, FCALL_END);
    // Selects kept in their own flops so no output passes through a compare
    rom_next    = req_i && tgt == TGT_ROM;
    ram_next    = req_i && tgt == TGT_RAM;
    sfr_next    = req_i && tgt == TGT_SFR;
    ext_next    = req_i && tgt == TGT_EXT;
    high_q_next = rel.high;
    done_q_next = rel.done;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      tgt_reg   <= TGT_NONE;
      off_reg   <= '0;
      gpr_reg   <= 1'b0;
      dreg_reg  <= 1'b0;
      vec_reg   <= 1'b0;
      tcall_reg  <= 1'b0;
      fcall_reg  <= 1'b0;
      rom_reg    <= 1'b0;
      ram_reg    <= 1'b0;
      sfr_reg    <= 1'b0;
      ext_reg    <= 1'b0;
      high_q_reg <= 1'b0;
      done_q_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      tgt_reg   <= tgt_next;
      off_reg   <= off_next;
      gpr_reg   <= gpr_next;
      dreg_reg  <= dreg_next;
      vec_reg   <= vec_next;
      tcall_reg  <= tcall_next;
      fcall_reg  <= fcall_next;
      rom_reg    <= rom_next;
      ram_reg    <= ram_next;
      sfr_reg    <= sfr_next;
      ext_reg    <= ext_next;
      high_q_reg <= high_q_next;
      done_q_reg <= done_q_next;
    end
  end

  assign valid_o      = valid_reg;
  assign target_o     = tgt_reg;
  assign offset_o     = off_reg;
  assign rom_sel_o    = rom_reg;
  assign ram_sel_o    = ram_reg;
  assign sfr_sel_o    = sfr_reg;
  assign ext_sel_o    = ext_reg;
  assign gpr_sel_o    = gpr_reg;
  assign dreg_sel_o   = dreg_reg;
  assign vec_sel_o    = vec_reg;
  assign tcall_sel_o  = tcall_reg;
  assign fcall_sel_o  = fcall_reg;
  assign reloc_high_o = high_q_reg;
  assign reloc_done_o = done_q_reg;

  chk_ext_mode_gate : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !ext_mode_i) |=> (target_o != TGT_EXT))
    else $error("external target without expansion mode");
  chk_shadow_hidden : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !reset_fetch_i && !rel.high && addr_i >= DLO && addr_i <= PAGE_MASK)
      |=> (target_o == TGT_RAM || target_o == TGT_SFR))
    else $error("ROM visible under low data area");
  chk_high_rom : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && rel.high && addr_i <= REND) |=> (target_o == TGT_ROM))
    else $error("ROM not reachable with high placement");
  chk_high_data : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !reset_fetch_i && rel.high && addr_i >= (DLO | HIGH_OFS))
      |=> (target_o inside {TGT_RAM, TGT_SFR}))
    else $error("high data area not decoded");
  chk_sfr_window : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !reset_fetch_i && !rel.high && addr_i >= SFR_BASE && addr_i <= PAGE_MASK)
      |=> (sfr_sel_o && offset_o == $past(addr_i) - SFR_BASE))
    else $error("register window decode wrong");
  chk_reset_fetch : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && reset_fetch_i) |=> !(ram_sel_o || sfr_sel_o))
    else $error("reset entry from RAM");
  chk_vec_table : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !reset_fetch_i && addr_i <= VEC_END) |=> vec_sel_o)
    else $error("vector table not selected");
  chk_gpr_bank : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_i && !reset_fetch_i && !rel.high && addr_i >= GPR_BASE && addr_i <= GPR_END)
      |=> (gpr_sel_o && dreg_sel_o))
    else $error("register bank decode wrong");
endmodule
`default_nettype wire

// ===== mem_decode_pkg.sv
// Package with address map constants and types for the memory space decoder
package mem_decode_pkg;
  localparam int ADDR_W = 20;
  typedef logic [19:0] addr_t;
  typedef logic [3:0]  reloc_t;
  localparam reloc_t RELOC_LOW  = 4'h0;
  localparam reloc_t RELOC_HIGH = 4'hf;
  // Variant selector: 0 smallest .. 3 largest
  typedef logic [1:0] variant_t;
  localparam variant_t VAR_48K  = 2'h0;
  localparam variant_t VAR_64K  = 2'h1;
  localparam variant_t VAR_96K  = 2'h2;
  localparam variant_t VAR_128K = 2'h3;
  // Data area low bound (low placement); high placement adds HIGH_OFS
  localparam addr_t DATA_LO_48K  = 20'h0f700;
  localparam addr_t DATA_LO_64K  = 20'h0f700;
  localparam addr_t DATA_LO_96K  = 20'h0f100;
  localparam addr_t DATA_LO_128K = 20'h0ee00;
  localparam addr_t HIGH_OFS     = 20'hf0000;
  // ROM end (inclusive) per variant
  localparam addr_t ROM_END_48K  = 20'h0bfff;
  localparam addr_t ROM_END_64K  = 20'h0ffff;
  localparam addr_t ROM_END_96K  = 20'h17fff;
  localparam addr_t ROM_END_128K = 20'h1ffff;
  // Fixed sub-areas: register window and banks in the low 64 KB image of the data area, vectors and call tables in ROM
  localparam addr_t SFR_BASE     = 20'h0ff00;
  localparam addr_t GPR_BASE     = 20'h0fe80;
  localparam addr_t GPR_END      = 20'h0feff;
  localparam addr_t DREG_BASE    = 20'h0fd00;
  localparam addr_t VEC_END      = 20'h0003f;
  localparam addr_t TCALL_BASE   = 20'h00040;
  localparam addr_t TCALL_END    = 20'h0007f;
  localparam addr_t FCALL_BASE   = 20'h00800;
  localparam addr_t FCALL_END    = 20'h00fff;
  localparam addr_t PAGE_MASK    = 20'h0ffff;
  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_ROM  = 3'b001,
    TGT_RAM  = 3'b010,
    TGT_SFR  = 3'b011,
    TGT_EXT  = 3'b100
  } target_e;
endpackage

// ===== reloc_if.sv
// Interface carrying the latched placement from the latch to the decoder
`timescale 1ns/1ps
`default_nettype none
interface reloc_if;
  logic high;
  logic done;
  modport latch (output high, output done);
  modport user  (input high, input done);
endinterface
`default_nettype wire

// ===== reloc_latch.sv
// One-time latch for the data-area placement
`timescale 1ns/1ps
`default_nettype none
module reloc_latch
  import mem_decode_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Relocation command from the core
  input  wire logic   reloc_valid_i,
  input  wire reloc_t reloc_code_i,
  // Placement out
  reloc_if.latch      rel
);
  logic high_reg, high_next;
  logic done_reg, done_next;

  always_comb begin
    high_next = high_reg;
    done_next = done_reg;
    if (reloc_valid_i && !done_reg) begin
      high_next = (reloc_code_i == RELOC_HIGH);
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      high_reg <= high_next;
      done_reg <= done_next;
    end
  end

  assign rel.high = high_reg;
  assign rel.done = done_reg;

  chk_reloc_hold : assert property (@(posedge clk_i) disable iff (rst_i)
    done_reg |=> (done_reg && high_reg == $past(high_reg)))
    else $error("placement changed after latch");
  chk_reloc_take : assert property (@(posedge clk_i) disable iff (rst_i)
    (reloc_valid_i && !done_reg) |=> (done_reg && high_reg == ($past(reloc_code_i) == RELOC_HIGH)))
    else $error("placement not latched");
endmodule
`default_nettype wire

// ===== cpu_model.sv
// Core-side model issuing accesses and the relocation command
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input  wire logic                   clk_i,
  // Access request and mode
  output var  logic                   req_o,
  output var  mem_decode_pkg::addr_t  addr_o,
  output var  logic                   reset_fetch_o,
  output var  logic                   ext_mode_o,
  // Relocation command
  output var  logic                   reloc_valid_o,
  output var  mem_decode_pkg::reloc_t reloc_code_o
);
  import mem_decode_pkg::*;
  logic issued;
  initial begin
    {req_o, reset_fetch_o, ext_mode_o, reloc_valid_o, issued} = '0;
    addr_o = '0;
    reloc_code_o = '0;
  end
  // Released bus drops req_o and flips its address lines so a stale address cannot look valid
  task automatic idle();
    req_o = 1'b0;
    addr_o = ~addr_o;
  endtask
  // No peripheral behind the window, every offset stands assigned
  // Request raised and held through the sampling edge; returns 1 ns after it with req_o still high
  task automatic access(addr_t a, logic f, logic e);
    req_o = 1'b1;
    addr_o = a;
    reset_fetch_o = f;
    ext_mode_o = e;
    @(posedge clk_i);
    #1;
  endtask
  // One command per reset unless a repeat is ordered
  task automatic relocate(reloc_t code, logic again);
    if (!issued || again) begin
      reloc_valid_o = 1'b1;
      reloc_code_o = code;
      @(posedge clk_i);
      #1;
      reloc_valid_o = 1'b0;
      reloc_code_o = ~code;
      issued = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb_memory_space_decoder.sv
// Self-checking bench for the decoder, all four ROM maps side by side
`timescale 1ns/1ps
`default_nettype none
module tb_memory_space_decoder;
  import mem_decode_pkg::*;
  logic        clk_i, rst_i, req, rf, ext, rv;
  addr_t       addr;
  reloc_t      code;
  logic [32:0] obs [4];
  logic [1:0]  stat [4];
  logic        exp_high, exp_done;
  int          bad_count, checked;
  const addr_t corner [32] = '{20'h00000, 20'h0003f, 20'h00040, 20'h0007f, 20'h007ff,
    20'h0f0ff, 20'h0f100, 20'h17fff, 20'h18000,
    20'h00800, 20'h00fff, 20'h01000, 20'h0bfff, 20'h0c000, 20'h0edff, 20'h0ee00,
    20'h0f6ff, 20'h0f700, 20'h0fcff, 20'h0fd00, 20'h0fe7f, 20'h0fe80, 20'h0feff,
    20'h0ff00, 20'h0ffff, 20'h10000, 20'h1ffff, 20'h20000, 20'hfedff, 20'hfee00,
    20'hff700, 20'hfffff};
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  cpu_model i_cpu (.clk_i(clk_i), .req_o(req), .addr_o(addr), .reset_fetch_o(rf),
    .ext_mode_o(ext), .reloc_valid_o(rv), .reloc_code_o(code));
  for (genvar g = 0; g < 4; g++) begin : g_dut
    mem_decoder #(.VARIANT(variant_t'(g))) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .req_i(req), .addr_i(addr), .reset_fetch_i(rf), .reloc_valid_i(rv),
      .reloc_code_i(code), .ext_mode_i(ext), .valid_o(obs[g][32]),
      .target_o(obs[g][31:29]), .offset_o(obs[g][28:9]), .rom_sel_o(obs[g][8]),
      .ram_sel_o(obs[g][7]), .sfr_sel_o(obs[g][6]), .gpr_sel_o(obs[g][5]),
      .dreg_sel_o(obs[g][4]), .ext_sel_o(obs[g][3]), .vec_sel_o(obs[g][2]),
      .tcall_sel_o(obs[g][1]), .fcall_sel_o(obs[g][0]), .reloc_high_o(stat[g][1]),
      .reloc_done_o(stat[g][0]));
  end
  function automatic logic [32:0] expect_dec(variant_t v, logic f, logic e, addr_t a);
    addr_t   lo, base, re, off;
    target_e t;
    logic    dat, rom;
    case (v)
      VAR_48K: begin
        lo = DATA_LO_48K;
        re = ROM_END_48K;
      end
      VAR_64K: begin
        lo = DATA_LO_64K;
        re = ROM_END_64K;
      end
      VAR_96K: begin
        lo = DATA_LO_96K;
        re = ROM_END_96K;
      end
      default: begin
        lo = DATA_LO_128K;
        re = ROM_END_128K;
      end
    endcase
    base = exp_high ? lo + HIGH_OFS : lo;
    dat = (a >= base) && (a[19:16] == base[19:16]);
    // Data area hides ROM except for reset fetch
    rom = (a <= re) && (f || !dat);
    off = a;
    if (rom) begin
      t = TGT_ROM;
    end else if (dat && !f) begin
      t = (a[15:8] == SFR_BASE[15:8]) ? TGT_SFR : TGT_RAM;
      off = (t == TGT_SFR) ? {12'h0, a[7:0]} : a - base;
    end else begin
      t = e ? TGT_EXT : TGT_NONE;
    end
    return {1'b1, t, off, t == TGT_ROM, t == TGT_RAM, t == TGT_SFR,
      t == TGT_RAM && a[15:0] >= GPR_BASE[15:0], t == TGT_RAM && a[15:0] >= DREG_BASE[15:0],
      t == TGT_EXT, rom && a <= VEC_END, rom && a >= TCALL_BASE && a <= TCALL_END,
      rom && a >= FCALL_BASE && a <= FCALL_END};
  endfunction
  task automatic cmp(logic [34:0] got, logic [34:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic probe(addr_t a, logic f, logic e);
    i_cpu.access(a, f, e);
    for (int g = 0; g < 4; g++) begin
      cmp({obs[g], stat[g]},
        {expect_dec(variant_t'(g), f, e, a), exp_high && exp_done, exp_done});
    end
  endtask
  task automatic sweep();
    logic [31:0] r;
    foreach (corner[i]) for (int k = 0; k < 4; k++) probe(corner[i], k[0], k[1]);
    for (int n = 0; n < 24; n++) begin
      r = $urandom;
      probe(r[20] ? r[19:0] : {{4{r[21]}}, 3'h7, r[12:0]}, r[22], r[23]);
    end
  endtask
  task automatic do_reset();
    i_cpu.idle();
    i_cpu.issued = 1'b0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    {exp_high, exp_done} = 2'b00;
    for (int g = 0; g < 4; g++) cmp({obs[g], stat[g]}, '0);
  endtask
  task automatic results();
    $display("checks made %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    void'($urandom(32'h4c7a));
    // Every code value, each after its own reset; non-F codes keep low placement
    for (int c = 0; c < 16; c++) begin
      do_reset();
      sweep();
      i_cpu.relocate(reloc_t'(c), 1'b0);
      exp_high = (c == 15);
      // Status flops show the command two edges on, which is when this probe compares
      exp_done = 1'b1;
      probe(20'h0ff00, 1'b0, 1'b1);
      i_cpu.relocate(reloc_t'(~c), 1'b1);
      sweep();
      $display("placement code %0d finished", c);
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("mismatch at %0t ns: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
